// ===== hcam_regs.vh
// Purpose: Constants for the heater circuit alarm monitor
// Assumes: 20 MHz core clock, byte addresses on the register port
// Notes: Definitions only
`ifndef HCAM_REGS_VH
`define HCAM_REGS_VH
// ***************************************************
// Geometry
// ***************************************************
`define HCAM_NCIRC 24
// ***************************************************
// Register offsets (byte addresses)
// ***************************************************
`define HCAM_A_CTRL 5'h00
`define HCAM_A_ACT 5'h04
`define HCAM_A_PAR 5'h08
`define HCAM_A_DLY 5'h0c
`define HCAM_A_SIL 5'h10
`define HCAM_A_STAT 5'h14
`define HCAM_A_ALM 5'h18
`define HCAM_A_FLT 5'h1c
// ***************************************************
// Fields and reset values
// ***************************************************
`define HCAM_CTRL_AUTO 0
`define HCAM_STAT_REMOTE 0
`define HCAM_STAT_SIL 1
`define HCAM_STAT_LAMP 2
`define HCAM_STAT_FIRST 3
`define HCAM_STAT_IDX 8
`define HCAM_RST_AUTO 1'h1
`define HCAM_RST_ACT 24'hffffff
`define HCAM_RST_PAR 24'h000000
`define HCAM_RST_DLY 4'h1
`define HCAM_RST_SIL 17'h00e10
// ***************************************************
// Timing
// ***************************************************
`define HCAM_CLK_NS 50
`define HCAM_SEC_NS 1000000000
`define HCAM_MS_NS 1000000
`define HCAM_LAMP_MS 1000
`define HCAM_STEP_MS 500
`define HCAM_DEB_MS 20
`define HCAM_DLY_W0 9'h01e
`define HCAM_DLY_W1 9'h03c
`define HCAM_DLY_W2 9'h05a
`define HCAM_DLY_W3 9'h078
`define HCAM_SIL_MAX 17'h15180
`endif

// ===== hcam_monitor.v
// Purpose: Alarm and indication logic for a 24 circuit heater scanner
// Assumes: Sensor flags and buttons arrive from pins, active high
// Notes: Remote alarm output is high while all is well
//
// Contract
// - Lamp test lights red and green together before scanning starts.
// - First scan after power-up or reset shows green under active circuits.
// - Green stays until call drops, or voltage, continuity or current fails.
// - Fault lasting the full delay lights red and raises remote alarm.
// - Manual mode: alarm latched until fault clears and reset pressed.
// - Auto mode: alarm and remote alarm clear when fault disappears.
// - Alarm delay selectable from 30 seconds to 5 minutes.
// - Alarm delay is the sum of the selected weights.
// - Silence press quiets remote alarm for the silence time, up to 24 h.
// - Silence expiry with fault still present reactivates remote alarm.
// - A circuit newly reaching its alarm delay ends silence at once.
// - Each silence press quiets alarm and restarts the silence timer.
// - Manual mode: reset press clears all latched alarms except those whose fault is still past its delay.
// - No call means no green after the first scan and no new alarm.
// - Energized circuit passing all checks shows green, no alarm.
// - Missing voltage while called lights red voltage and alarms.
// - Current below threshold lights red current and alarms.
// - Parallel circuit failing continuity lights red continuity, alarms.
// - Display shows the number of the circuit being scanned.
// - Alarm output asserted in normal operation.
// - Inactive circuits are skipped and never monitored.
// - Voltage, current, continuity judged only while call is closed.
`include "hcam_regs.vh"
module hcam_monitor #(
  parameter SEC_CYC = `HCAM_SEC_NS / `HCAM_CLK_NS,
  parameter LAMP_CYC = `HCAM_LAMP_MS * (`HCAM_MS_NS / `HCAM_CLK_NS),
  parameter STEP_CYC = `HCAM_STEP_MS * (`HCAM_MS_NS / `HCAM_CLK_NS),
  parameter DEB_CYC = `HCAM_DEB_MS * (`HCAM_MS_NS / `HCAM_CLK_NS)
) (
  // Clock, reset, enable
  input wire core_clk_in,
  input wire resetn_in,
  input wire clk_en_in,
  // Sensor card flags, one bit per circuit
  input wire [23:0] call_in,
  input wire [23:0] volt_in,
  input wire [23:0] curr_in,
  input wire [23:0] cont_in,
  // Front buttons
  input wire silence_btn_in,
  input wire reset_btn_in,
  // Register port
  input wire [4:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  // Indicators and alarm
  output reg [23:0] green_out,
  output reg [23:0] red_volt_out,
  output reg [23:0] red_curr_out,
  output reg [23:0] red_cont_out,
  output reg [4:0] disp_num_out,
  output reg remote_alarm_out
);
  localparam N = `HCAM_NCIRC;
  localparam integer SEC_LAST = SEC_CYC - 1;
  localparam integer LAMP_LAST = LAMP_CYC - 1;
  localparam integer STEP_LAST = STEP_CYC - 1;
  localparam integer DEB_LAST = DEB_CYC - 1;
  localparam [1:0] ST_LAMP = 2'h1;
  localparam [1:0] ST_SCAN = 2'h2;

  // ***************************************************
  // Functions
  // ***************************************************
  // Next active circuit after cur, wrapping; cur if none
  function [4:0] hcam_next;
    input [23:0] m;
    input [4:0] cur;
    integer k;
    integer j;
    reg f;
    begin
      hcam_next = cur;
      f = 1'b0;
      for (k = 1; k <= N; k = k + 1) begin
        j = (cur + k) % N;
        if (!f && m[j]) begin
          hcam_next = j[4:0];
          f = 1'b1;
        end
      end
    end
  endfunction

  // Sum of selected delay weights in seconds, 30 s floor
  function [8:0] hcam_dly;
    input [3:0] s;
    reg [8:0] t;
    begin
      t = (s[0] ? `HCAM_DLY_W0 : 9'h000) +
          (s[1] ? `HCAM_DLY_W1 : 9'h000) +
          (s[2] ? `HCAM_DLY_W2 : 9'h000) +
          (s[3] ? `HCAM_DLY_W3 : 9'h000);
      hcam_dly = (t == 9'h000) ? `HCAM_DLY_W0 : t;
    end
  endfunction

  // ***************************************************
  // Input synchronisers
  // ***************************************************
  wire [97:0] raw;
  reg [97:0] sy_a;
  reg [97:0] sy_b;
  reg [97:0] sy_c;
  reg [97:0] flt;
  assign raw = {reset_btn_in, silence_btn_in, cont_in, curr_in,
    volt_in, call_in};

  // Three stages; a level counts once stages two and three agree
  always @(posedge core_clk_in) begin
    if (!resetn_in) begin
      sy_a <= {98{1'b0}};
      sy_b <= {98{1'b0}};
      sy_c <= {98{1'b0}};
      flt <= {98{1'b0}};
    end else if (clk_en_in) begin
      sy_a <= raw;
      sy_b <= sy_a;
      sy_c <= sy_b;
      flt <= (sy_b & sy_c) | (flt & (sy_b ^ sy_c));
    end
  end

  wire [23:0] call = flt[23:0];
  wire [23:0] volt = flt[47:24];
  wire [23:0] curr = flt[71:48];
  wire [23:0] cont = flt[95:72];

  // ***************************************************
  // Button debounce
  // ***************************************************
  wire [1:0] press;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_btn
      reg [24:0] cnt;
      reg st;
      reg p;
      assign press[g] = p;
      // Level must hold a full window; one pulse per rising edge
      always @(posedge core_clk_in) begin
        if (!resetn_in) begin
          cnt <= 25'h0000000;
          st <= 1'b0;
          p <= 1'b0;
        end else if (clk_en_in) begin
          p <= 1'b0;
          if (flt[96 + g] == st) begin
            cnt <= 25'h0000000;
          end else if (cnt == DEB_LAST[24:0]) begin
            cnt <= 25'h0000000;
            st <= flt[96 + g];
            p <= flt[96 + g];
          end else begin
            cnt <= cnt + 25'h0000001;
          end
        end
      end
    end
  endgenerate
  wire sil_press = press[0];
  wire rst_press = press[1];

  // ***************************************************
  // One second tick
  // ***************************************************
  reg [24:0] sec_cnt;
  reg sec_tick;
  always @(posedge core_clk_in) begin
    if (!resetn_in) begin
      sec_cnt <= 25'h0000000;
      sec_tick <= 1'b0;
    end else if (clk_en_in) begin
      sec_tick <= (sec_cnt == SEC_LAST[24:0]);
      sec_cnt <= (sec_cnt == SEC_LAST[24:0]) ? 25'h0000000 :
        sec_cnt + 25'h0000001;
    end
  end

  // ***************************************************
  // Configuration registers
  // ***************************************************
  reg ctrl_auto;
  reg [23:0] act_mask;
  reg [23:0] par_mask;
  reg [3:0] dly_sel;
  reg [16:0] sil_time;
  always @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ctrl_auto <= `HCAM_RST_AUTO;
      act_mask <= `HCAM_RST_ACT;
      par_mask <= `HCAM_RST_PAR;
      dly_sel <= `HCAM_RST_DLY;
      sil_time <= `HCAM_RST_SIL;
    end else if (clk_en_in && reg_wr_in) begin
      case (reg_addr_in)
        `HCAM_A_CTRL: ctrl_auto <= reg_wdata_in[`HCAM_CTRL_AUTO];
        `HCAM_A_ACT: act_mask <= reg_wdata_in[23:0];
        `HCAM_A_PAR: par_mask <= reg_wdata_in[23:0];
        `HCAM_A_DLY: dly_sel <= reg_wdata_in[3:0];
        // Clamp to a day so the silence never outlasts 24 h
        `HCAM_A_SIL: sil_time <= (reg_wdata_in[31:0] >
          {15'h0000, `HCAM_SIL_MAX}) ? `HCAM_SIL_MAX :
          reg_wdata_in[16:0];
        default: ;
      endcase
    end
  end

  // ***************************************************
  // Scan sequencer
  // ***************************************************
  reg [1:0] state;
  reg [24:0] ph_cnt;
  reg [4:0] idx;
  reg first_scan;
  wire run = (state == ST_SCAN);
  wire [4:0] nxt = hcam_next(act_mask, idx);
  always @(posedge core_clk_in) begin
    if (!resetn_in) begin
      state <= ST_LAMP;
      ph_cnt <= 25'h0000000;
      idx <= 5'h00;
      first_scan <= 1'b0;
    end else if (clk_en_in) begin
      case (state)
        ST_LAMP: begin
          if (ph_cnt == LAMP_LAST[24:0]) begin
            ph_cnt <= 25'h0000000;
            state <= ST_SCAN;
            idx <= hcam_next(act_mask, 5'h17);
            first_scan <= 1'b1;
          end else begin
            ph_cnt <= ph_cnt + 25'h0000001;
          end
        end
        ST_SCAN: begin
          if (ph_cnt == STEP_LAST[24:0]) begin
            ph_cnt <= 25'h0000000;
            idx <= nxt;
            if (nxt <= idx) begin
              first_scan <= 1'b0;
            end
          end else begin
            ph_cnt <= ph_cnt + 25'h0000001;
          end
          // Reset press starts a fresh all-green first pass
          if (rst_press) begin
            first_scan <= 1'b1;
          end
        end
        default: begin
          state <= ST_LAMP;
          ph_cnt <= 25'h0000000;
        end
      endcase
    end
  end

  // ***************************************************
  // Fault detection and per circuit alarms
  // ***************************************************
  // Checks only while called and active; idle circuits never alarm
  wire [23:0] live = act_mask & call & {N{run}};
  wire [23:0] f_volt = live & ~volt;
  wire [23:0] f_curr = live & ~curr;
  wire [23:0] f_cont = live & par_mask & ~cont;
  wire [23:0] fault = f_volt | f_curr | f_cont;
  wire [8:0] dly = hcam_dly(dly_sel);
  wire [23:0] alm;
  wire [23:0] set_evt;
  wire [23:0] av;
  wire [23:0] ac;
  wire [23:0] at;
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_ckt
      reg [8:0] dcnt;
      reg a;
      reg rv;
      reg rc;
      reg rt;
      wire due = fault[i] && (dcnt > dly); // First tick is partial
      assign set_evt[i] = due && !a;
      assign alm[i] = a;
      assign av[i] = rv;
      assign ac[i] = rc;
      assign at[i] = rt;
      // Timer runs only while fault holds; set wins over any clear
      always @(posedge core_clk_in) begin
        if (!resetn_in) begin
          dcnt <= 9'h000;
          a <= 1'b0;
          rv <= 1'b0;
          rc <= 1'b0;
          rt <= 1'b0;
        end else if (clk_en_in) begin
          if (!fault[i]) begin
            dcnt <= 9'h000;
          end else if (sec_tick && dcnt <= dly) begin
            dcnt <= dcnt + 9'h001;
          end
          if (due) begin
            a <= 1'b1;
            rv <= rv | f_volt[i];
            rc <= rc | f_curr[i];
            rt <= rt | f_cont[i];
          end else if (rst_press ||
                       (ctrl_auto && !fault[i])) begin
            a <= 1'b0;
            rv <= 1'b0;
            rc <= 1'b0;
            rt <= 1'b0;
          end
        end
      end
    end
  endgenerate
  wire any_alm = |alm;

  // ***************************************************
  // Silence timer
  // ***************************************************
  reg silenced;
  reg [16:0] sil_cnt;
  always @(posedge core_clk_in) begin
    if (!resetn_in) begin
      silenced <= 1'b0;
      sil_cnt <= 17'h00000;
    end else if (clk_en_in) begin
      if (|set_evt) begin
        silenced <= 1'b0;
      end else if (sil_press && any_alm) begin
        silenced <= 1'b1;
        sil_cnt <= 17'h00000;
      end else if (silenced) begin
        if (!any_alm) begin
          silenced <= 1'b0;
        end else if (sec_tick) begin
          if (sil_cnt >= sil_time) begin // Partial first tick
            silenced <= 1'b0;
          end else begin
            sil_cnt <= sil_cnt + 17'h00001;
          end
        end
      end
    end
  end

  // ***************************************************
  // Indicator and alarm outputs
  // ***************************************************
  // Green drops at once on a fault; red waits for the delay
  always @(posedge core_clk_in) begin
    if (!resetn_in) begin
      green_out <= 24'h000000;
      red_volt_out <= 24'h000000;
      red_curr_out <= 24'h000000;
      red_cont_out <= 24'h000000;
      disp_num_out <= 5'h00;
      remote_alarm_out <= 1'b1;
    end else if (clk_en_in) begin
      if (!run) begin
        green_out <= 24'hffffff;
        red_volt_out <= 24'hffffff;
        red_curr_out <= 24'hffffff;
        red_cont_out <= 24'hffffff;
        disp_num_out <= 5'h00;
      end else begin
        green_out <= first_scan ? act_mask :
          (live & ~fault & ~alm);
        red_volt_out <= av;
        red_curr_out <= ac;
        red_cont_out <= at;
        disp_num_out <= act_mask[idx] ? idx + 5'h01 : 5'h00;
      end
      // High means healthy, so a dead panel reads as a fault
      remote_alarm_out <= ~(any_alm & ~silenced);
    end
  end

  // ***************************************************
  // Register read port
  // ***************************************************
  // Data stand one cycle after the strobe, zero otherwise
  always @(posedge core_clk_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (clk_en_in) begin
      reg_rdata_out <= 32'h00000000;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `HCAM_A_CTRL: reg_rdata_out <= {31'h00000000, ctrl_auto};
          `HCAM_A_ACT: reg_rdata_out <= {8'h00, act_mask};
          `HCAM_A_PAR: reg_rdata_out <= {8'h00, par_mask};
          `HCAM_A_DLY: reg_rdata_out <= {28'h0000000, dly_sel};
          `HCAM_A_SIL: reg_rdata_out <= {15'h0000, sil_time};
          `HCAM_A_STAT: reg_rdata_out <= {19'h00000, idx, 4'h0,
            first_scan, ~run, silenced, remote_alarm_out};
          `HCAM_A_ALM: reg_rdata_out <= {8'h00, alm};
          `HCAM_A_FLT: reg_rdata_out <= {8'h00, fault};
          default: reg_rdata_out <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ===== hcam_monitor_chk.sv
// Purpose: Port-level assertions for the heater circuit alarm monitor
// Assumes: Debounce of 3 cycles; buttons never meet a fault edge
// Notes: Bound into every monitor instance
module hcam_monitor_chk (
  // Clock, reset, enable
  input wire core_clk_in,
  input wire resetn_in,
  input wire clk_en_in,
  // Field pins
  input wire [23:0] call_in,
  input wire [23:0] volt_in,
  input wire [23:0] curr_in,
  input wire [23:0] cont_in,
  input wire silence_btn_in,
  input wire reset_btn_in,
  // Register port and indicators
  input wire reg_rd_in,
  input wire [31:0] reg_rdata_out,
  input wire [23:0] green_out,
  input wire [23:0] red_volt_out,
  input wire [23:0] red_curr_out,
  input wire [23:0] red_cont_out,
  input wire [4:0] disp_num_out,
  input wire remote_alarm_out
);
  wire [23:0] any_red;
  wire no_fault;
  // Red of any type, and pins free of any called fault
  assign any_red = red_volt_out | red_curr_out | red_cont_out;
  assign no_fault = (call_in & ~(volt_in & curr_in & cont_in)) == 24'h0;
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // Presses held long enough to pass the debounce
  sequence s_sil_press;
    (!remote_alarm_out && $rose(silence_btn_in)) ##1 silence_btn_in [*4];
  endsequence
  sequence s_rst_press;
    (no_fault && $rose(reset_btn_in)) ##1 reset_btn_in [*4];
  endsequence
  a_lamp_test: assert property ($rose(resetn_in) |-> ##[1:3]
    (&green_out && &red_volt_out && &red_curr_out && &red_cont_out))
    else $error("lamp test missing after reset");
  a_alarm_red: assert property ($fell(remote_alarm_out) |->
    ##[0:1] (any_red != 24'h0)) else $error("alarm without red bar");
  a_new_alarm: assert property (((any_red & ~$past(any_red)) != 0
    && !(&any_red)) |-> ##[0:1] !remote_alarm_out)
    else $error("new alarm did not sound");
  a_sil_quiet: assert property (s_sil_press |->
    ##[0:10] remote_alarm_out) else $error("silence press ignored");
  a_sil_early: assert property (!remote_alarm_out &&
    $rose(silence_btn_in) |=> !remote_alarm_out [*2])
    else $error("button acted before sync");
  a_rst_clear: assert property (s_rst_press |-> ##[0:10]
    (any_red == 24'h0 && remote_alarm_out))
    else $error("reset press left alarms");
  a_disp_range: assert property (disp_num_out <= 5'h18)
    else $error("display beyond last circuit");
  a_rdata_idle: assert property ((!reg_rd_in && clk_en_in) |=>
    reg_rdata_out == 32'h0) else $error("read data outside its cycle");
  a_freeze_hold: assert property (!clk_en_in |=> $stable(green_out)
    && $stable(disp_num_out) && $stable(remote_alarm_out))
    else $error("outputs moved while frozen");
endmodule
bind hcam_monitor hcam_monitor_chk i_chk (.core_clk_in(core_clk_in),
  .resetn_in(resetn_in), .clk_en_in(clk_en_in), .call_in(call_in),
  .volt_in(volt_in), .curr_in(curr_in), .cont_in(cont_in),
  .silence_btn_in(silence_btn_in), .reset_btn_in(reset_btn_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .green_out(green_out), .red_volt_out(red_volt_out),
  .red_curr_out(red_curr_out), .red_cont_out(red_cont_out),
  .disp_num_out(disp_num_out), .remote_alarm_out(remote_alarm_out));

// ===== hcam_field_model.sv
// Purpose: Sensor cards and front buttons facing the monitor
// Assumes: Bench gives fault masks; one-cycle requests start presses
// Notes: A press holds 8 cycles, well beyond the debounce window
module hcam_field_model (
  // Clock and bench requests
  input wire core_clk_in,
  input wire sil_req_in,
  input wire rst_req_in,
  input wire [23:0] call_m_in,
  input wire [23:0] volt_bad_in,
  input wire [23:0] curr_bad_in,
  input wire [23:0] cont_bad_in,
  // Pins toward the monitor
  output wire [23:0] call_out,
  output wire [23:0] volt_out,
  output wire [23:0] curr_out,
  output wire [23:0] cont_out,
  output wire silence_btn_out,
  output wire reset_btn_out
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [3:0] sil_cnt = 4'h0;
  reg [3:0] rst_cnt = 4'h0;
  // Cards report good levels high, faults as low
  assign call_out = call_m_in;
  assign volt_out = ~volt_bad_in;
  assign curr_out = ~curr_bad_in;
  assign cont_out = ~cont_bad_in;
  assign silence_btn_out = sil_cnt != 4'h0;
  assign reset_btn_out = rst_cnt != 4'h0;
  // Press length counters, clean edges with no bounce
  always @(posedge core_clk_in) begin
    sil_cnt <= sil_req_in ? 4'h8 : sil_cnt - (sil_cnt != 4'h0);
    rst_cnt <= rst_req_in ? 4'h8 : rst_cnt - (rst_cnt != 4'h0);
  end
endmodule

// ===== tb_top.sv
// Purpose: Self-checking bench for the heater circuit alarm monitor
// Assumes: Second, lamp, step and debounce shortened by parameters
// Notes: Expectations come from a small model of the rules
`include "hcam_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer SEC = 20;
  reg core_clk_in = 1'b0, resetn_in = 1'b0, clk_en_in = 1'b1;
  reg reg_wr_in = 1'b0, reg_rd_in = 1'b0, sil_req = 1'b0, rst_req = 1'b0;
  reg [4:0] reg_addr_in = 5'h00;
  reg [31:0] reg_wdata_in = 32'h0, rd, seen;
  reg [23:0] call_m = 24'h0, volt_bad = 24'h0, curr_bad = 24'h0;
  reg [23:0] cont_bad = 24'h0, exp_bar, act = 24'hf, par = 24'h8;
  reg [3:0] k;
  wire [23:0] call_in, volt_in, curr_in, cont_in, green_out;
  wire [23:0] red_volt_out, red_curr_out, red_cont_out;
  wire [31:0] reg_rdata_out;
  wire [4:0] disp_num_out;
  wire silence_btn_in, reset_btn_in, remote_alarm_out;
  integer miscompares = 0, checks_done = 0, cycles = 0;
  integer seed = 32'hef80, n, i, j, w;
  hcam_monitor #(.SEC_CYC(SEC), .LAMP_CYC(10), .STEP_CYC(4), .DEB_CYC(3))
    i_dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .clk_en_in(clk_en_in), .call_in(call_in), .volt_in(volt_in),
    .curr_in(curr_in), .cont_in(cont_in), .silence_btn_in(silence_btn_in),
    .reset_btn_in(reset_btn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .green_out(green_out), .red_volt_out(red_volt_out),
    .red_curr_out(red_curr_out), .red_cont_out(red_cont_out),
    .disp_num_out(disp_num_out), .remote_alarm_out(remote_alarm_out));
  hcam_field_model i_field (.core_clk_in(core_clk_in),
    .sil_req_in(sil_req), .rst_req_in(rst_req), .call_m_in(call_m),
    .volt_bad_in(volt_bad), .curr_bad_in(curr_bad), .cont_bad_in(cont_bad),
    .call_out(call_in), .volt_out(volt_in), .curr_out(curr_in),
    .cont_out(cont_in), .silence_btn_out(silence_btn_in),
    .reset_btn_out(reset_btn_in));
  // ****************************************
  // Clock, hang guard, shared tasks
  // ****************************************
  initial forever #25 core_clk_in = ~core_clk_in;
  // Longest path is the 5 minute delay, about 6000 cycles
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares = miscompares + 1;
      $display("Error at %0t: run too long", $time);
      complete_run;
    end
  end
  task note(input ok, input [8*16-1:0] msg);
    begin
      checks_done = checks_done + 1;
      if (!ok) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: %0s", $time, msg);
      end
    end
  endtask
  task cmp_reg(input [31:0] got, input [31:0] exp);
    note(got === exp, "register value");
  endtask
  task cmp_bar(input [23:0] got, input [23:0] exp);
    note(got === exp, "indicator bars");
  endtask
  task cmp_time(input integer got, input integer lo, input integer hi);
    note(got >= lo && got <= hi, "alarm timing");
  endtask
  task complete_run;
    begin
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task wr(input [4:0] a, input [31:0] d);
    begin
      @(posedge core_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
    end
  endtask
  // Data stand only in the cycle after the strobe
  task rdr(input [4:0] a, output [31:0] d);
    begin
      @(posedge core_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      @(negedge core_clk_in);
      d = reg_rdata_out;
    end
  endtask
  task press(input s);
    begin
      @(posedge core_clk_in);
      sil_req <= s;
      rst_req <= !s;
      @(posedge core_clk_in);
      sil_req <= 1'b0;
      rst_req <= 1'b0;
    end
  endtask
  // Field change plus the model of the live green bars
  task set_field(input [23:0] c, v, cu, co);
    begin
      @(posedge core_clk_in);
      call_m <= c;
      volt_bad <= v;
      curr_bad <= cu;
      cont_bad <= co;
      exp_bar = act & c & ~v & ~cu & ~(co & par);
    end
  endtask
  task wait_rem(input v, input integer lim);
    begin
      n = 0;
      while (remote_alarm_out !== v && n < lim) begin
        @(negedge core_clk_in);
        n = n + 1;
      end
    end
  endtask
  function [31:0] rst_val(input integer r);
    case (r)
      0: rst_val = `HCAM_RST_AUTO;
      1: rst_val = `HCAM_RST_ACT;
      2: rst_val = `HCAM_RST_PAR;
      3: rst_val = `HCAM_RST_DLY;
      default: rst_val = `HCAM_RST_SIL;
    endcase
  endfunction
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(negedge core_clk_in);
    cmp_bar(green_out & red_volt_out, 24'hffffff);
    for (i = 0; i < 5; i = i + 1) begin
      rdr(5'(4 * i), rd);
      cmp_reg(rd, rst_val(i));
    end
    rdr(5'h02, rd);
    cmp_reg(rd, 32'h0);
    wr(`HCAM_A_ALM, $random(seed));
    rdr(`HCAM_A_ALM, rd);
    cmp_reg(rd, 32'h0);
    wr(`HCAM_A_SIL, 32'h0001ffff);
    rdr(`HCAM_A_SIL, rd);
    cmp_reg(rd, `HCAM_SIL_MAX);
    wr(`HCAM_A_ACT, {8'h0, act});
    wr(`HCAM_A_PAR, {8'h0, par});
    repeat (120) @(negedge core_clk_in);
    press(1'b0);
    n = 0;
    while (green_out !== act && n < 20) begin
      @(negedge core_clk_in);
      n = n + 1;
    end
    cmp_time(n, 0, 19);
    seen = 32'h1;
    for (i = 0; i < 40; i = i + 1) begin
      @(negedge core_clk_in);
      seen = seen | (32'h1 << disp_num_out);
    end
    cmp_reg(seen, 32'h1f);
    cmp_bar(green_out, 24'h0);
    set_field(24'h1b, 24'h14, 24'h0, 24'h2);
    repeat (40) @(negedge core_clk_in);
    cmp_bar(green_out, exp_bar);
    cmp_bar({23'h0, remote_alarm_out}, 24'h1);
    @(posedge core_clk_in) clk_en_in <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    clk_en_in <= 1'b1;
    for (j = 0; j < 3; j = j + 1) begin
      k = j == 0 ? 4'h1 : j == 1 ? 4'h9 : 4'hf;
      w = 30 * k[0] + 60 * k[1] + 90 * k[2] + 120 * k[3];
      wr(`HCAM_A_DLY, {28'h0, k});
      if (j == 0) begin
        set_field(24'h1b, 24'h15, 24'h0, 24'h2);
        repeat (25 * SEC) @(negedge core_clk_in);
        cmp_bar(green_out, exp_bar);
        set_field(24'h1b, 24'h14, 24'h0, 24'h2);
        repeat (10) @(negedge core_clk_in);
      end
      set_field(24'h1b, j == 0 ? 24'h15 : 24'h14, j == 1 ? 24'h2 : 24'h0,
        j == 2 ? 24'ha : 24'h2);
      wait_rem(1'b0, 7000);
      cmp_time(n, w * SEC, (w + 1) * SEC + 12);
      cmp_bar(red_volt_out, j == 0 ? 24'h1 : 24'h0);
      cmp_bar(red_curr_out, j == 1 ? 24'h2 : 24'h0);
      cmp_bar(red_cont_out, j == 2 ? 24'h8 : 24'h0);
      set_field(24'h1b, 24'h14, 24'h0, 24'h2);
      wait_rem(1'b1, 20);
      cmp_time(n, 0, 19);
      repeat (2) @(negedge core_clk_in);
      cmp_bar(red_volt_out | red_curr_out | red_cont_out, 24'h0);
    end
    wr(`HCAM_A_CTRL, 32'h0);
    wr(`HCAM_A_DLY, 32'h1);
    wr(`HCAM_A_SIL, 32'd40);
    set_field(24'h1b, 24'h15, 24'h0, 24'h2);
    wait_rem(1'b0, 700);
    cmp_time(n, 30 * SEC, 31 * SEC + 12);
    press(1'b1);
    wait_rem(1'b1, 20);
    cmp_time(n, 4, 19);
    set_field(24'h1b, 24'h15, 24'h2, 24'h2);
    wait_rem(1'b0, 700);
    cmp_time(n, 30 * SEC, 31 * SEC + 12);
    cmp_bar(red_curr_out, 24'h2);
    wr(`HCAM_A_SIL, 32'd2);
    press(1'b1);
    repeat (30) @(negedge core_clk_in);
    press(1'b1);
    wait_rem(1'b0, 200);
    cmp_time(n, 2 * SEC, 3 * SEC + 15);
    set_field(24'h1b, 24'h0, 24'h0, 24'h0);
    repeat (50) @(negedge core_clk_in);
    cmp_bar({23'h0, remote_alarm_out}, 24'h0);
    cmp_bar(red_volt_out | red_curr_out, 24'h3);
    press(1'b0);
    wait_rem(1'b1, 20);
    cmp_time(n, 4, 19);
    repeat (2) @(negedge core_clk_in);
    cmp_bar(red_volt_out | red_curr_out | red_cont_out, 24'h0);
    complete_run;
  end
endmodule
